// >>> core/qmc_map.svh
`ifndef QMC_MAP_SVH
`define QMC_MAP_SVH

// ---------------------------------------------------------------------
// Serial word layout
// ---------------------------------------------------------------------
`define QMC_WORD_BITS 5'd16
`define QMC_ADDR_LAST_BIT 5'd7
`define QMC_RW_BIT 15
`define QMC_ADDR_HI 14
`define QMC_ADDR_LO 8

// ---------------------------------------------------------------------
// Register offsets and fields
// ---------------------------------------------------------------------
`define QMC_SOFT_RESET_CONTROL 7'h00
`define QMC_POWER_AND_FORMAT_CONTROL 7'h01
`define QMC_OUTPUT_DRIVER_CONTROL 7'h02
`define QMC_SOFT_RESET_BIT 7
`define QMC_REG_RESET 8'h00

// Drive current in units of 0.01 mA
`define QMC_CUR_3P50 10'h15e
`define QMC_CUR_4P00 10'h190
`define QMC_CUR_4P50 10'h1c2
`define QMC_CUR_3P00 10'h12c
`define QMC_CUR_2P50 10'h0fa
`define QMC_CUR_2P10 10'h0d2
`define QMC_CUR_1P75 10'h0af
`define QMC_CUR_NONE 10'h000

// Serialization decode
`define QMC_BITS_16 5'h10
`define QMC_BITS_14 5'h0e
`define QMC_BITS_12 5'h0c
`define QMC_LANES_1 2'h1
`define QMC_LANES_2 2'h2

`endif

// >>> core/qmc_pkg.sv
package qmc_pkg;

  // -------------------------------------------------------------------
  // Register layouts
  // -------------------------------------------------------------------
  typedef struct packed {
    logic dutyStabilizerDisable;
    logic outputScramblerEnable;
    logic signedFormatSelect;
    logic sleepMode;
    logic [3:0] channelNap;
  } qmc_power_s;

  typedef struct packed {
    logic [2:0] driveCurrentSelect;
    logic internalTerminationEnable;
    logic outputsDisable;
    logic [2:0] serializationModeSelect;
  } qmc_output_s;

  // Serial configuration pins as seen by the device
  typedef struct packed {
    logic csN;
    logic sck;
    logic sdi;
    logic programmingStyleSelect;
  } qmc_pins_s;

  typedef logic [13:0] qmc_sample_t;

endpackage : qmc_pkg

// >>> core/qmc_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for pins arriving from outside the clock domain
module qmc_sync #(
  parameter int WIDTH = 1
) (
  // Clocking
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // -------------------------------------------------------------------
  // Synchroniser
  // -------------------------------------------------------------------
  // First stage feeds only the second stage
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else if (ce)
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : qmc_sync

`default_nettype wire

// >>> core/qmc_mode_regs.sv
// How it works
// - Reset register at address 0, bit 7.
// - Reset bit write clears all; self-clears.
// - Power bit 7 disables duty stabilizer.
// - Power bit 6 enables output scrambler.
// - Power bit 5 selects two's complement.
// - All-zero sleep/nap field: channels normal.
// - Bits 0-3 nap channels 1-4 independently.
// - Bit 4 sleep disables all channels.
// - Output register at address 2, fields.
// - Output bit 4 enables internal termination.
// - Termination doubles selected drive current.
// - Scrambler XORs upper bits with LSB.
// - Output bit 3 disables digital outputs.
// - Serialization codes select lanes and bits.
// - 16-bit word: flag, address, data; read.
`timescale 1ns/1ps
`default_nettype none
`include "qmc_map.svh"

module qmc_mode_regs (
  // Clocking
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // Serial configuration pins
  input wire qmc_pkg::qmc_pins_s pins,
  output logic sdoOut,
  output logic sdoOe,
  // Converter sample path
  input wire qmc_pkg::qmc_sample_t sampleIn,
  input wire logic sampleValid,
  output qmc_pkg::qmc_sample_t sampleOut,
  output logic sampleOutValid,
  // Mode controls
  output qmc_pkg::qmc_power_s powerCtl,
  output qmc_pkg::qmc_output_s outputCtl,
  output logic [3:0] channelEnable,
  output logic outputsEnable,
  output logic [9:0] driveCurrent,
  output logic [1:0] laneCount,
  output logic [4:0] wordBits
);
  import qmc_pkg::*;

  // -------------------------------------------------------------------
  // Pin synchronisation
  // -------------------------------------------------------------------
  qmc_pins_s pinsS;
  logic sckPrev_r;
  logic sckRise;
  logic sckFall;
  logic serialMode;

  qmc_sync #(.WIDTH(4)) uSync (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .d(pins),
    .q(pinsS)
  );

  // Edge detect on the synchronised clock only
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      sckPrev_r <= 1'b0;
    else if (ce)
      sckPrev_r <= pinsS.sck;
  end

  // Parallel strap high leaves the serial port deaf
  assign serialMode = !pinsS.programmingStyleSelect && !pinsS.csN;
  assign sckRise = serialMode && pinsS.sck && !sckPrev_r;
  assign sckFall = serialMode && !pinsS.sck && sckPrev_r;

  // -------------------------------------------------------------------
  // Serial word capture
  // -------------------------------------------------------------------
  logic [4:0] bitCnt_r;
  logic [14:0] shift_r;
  logic [15:0] word;
  logic doCommit;
  logic doWrite;
  logic [6:0] wrAddr;
  logic [7:0] wrData;

  assign word = {shift_r, pinsS.sdi};
  assign doCommit = sckRise && (bitCnt_r == `QMC_WORD_BITS - 5'd1);
  assign doWrite = doCommit && !word[`QMC_RW_BIT];
  assign wrAddr = word[`QMC_ADDR_HI:`QMC_ADDR_LO];
  assign wrData = word[7:0];

  // Edges past the sixteenth are ignored until chip select rises
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      bitCnt_r <= 5'h00;
      shift_r <= 15'h0000;
    end
    else if (ce)
    begin
      if (!serialMode)
        bitCnt_r <= 5'h00;
      else if (sckRise && bitCnt_r != `QMC_WORD_BITS)
      begin
        shift_r <= word[14:0];
        bitCnt_r <= bitCnt_r + 5'h01;
      end
    end
  end

  // -------------------------------------------------------------------
  // Mode registers
  // -------------------------------------------------------------------
  logic [7:0] pwrReg_r;
  logic [7:0] outReg_r;
  logic softReset;

  assign softReset = doWrite && wrAddr == `QMC_SOFT_RESET_CONTROL
    && wrData[`QMC_SOFT_RESET_BIT];

  // Soft reset bit is never stored, so it reads back as zero
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pwrReg_r <= `QMC_REG_RESET;
      outReg_r <= `QMC_REG_RESET;
    end
    else if (ce)
    begin
      if (softReset)
      begin
        pwrReg_r <= `QMC_REG_RESET;
        outReg_r <= `QMC_REG_RESET;
      end
      else if (doWrite && wrAddr == `QMC_POWER_AND_FORMAT_CONTROL)
        pwrReg_r <= wrData;
      else if (doWrite && wrAddr == `QMC_OUTPUT_DRIVER_CONTROL)
        outReg_r <= wrData;
    end
  end

  // -------------------------------------------------------------------
  // Readback on the open-drain data out
  // -------------------------------------------------------------------
  logic [7:0] rdData_r;
  logic rdActive_r;
  logic [7:0] rdValue;
  logic [6:0] rdAddr;
  logic addrDone;

  assign rdAddr = word[6:0];
  assign addrDone = sckRise && bitCnt_r == `QMC_ADDR_LAST_BIT;

  // Reset register and unmapped addresses read as zero
  always_comb
  begin
    case (rdAddr)
      `QMC_POWER_AND_FORMAT_CONTROL: rdValue = pwrReg_r;
      `QMC_OUTPUT_DRIVER_CONTROL: rdValue = outReg_r;
      default: rdValue = 8'h00;
    endcase
  end

  // Data leaves MSB first on falling edges; a one is released, not driven
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rdData_r <= 8'h00;
      rdActive_r <= 1'b0;
      sdoOe <= 1'b0;
      sdoOut <= 1'b0;
    end
    else if (ce)
    begin
      sdoOut <= 1'b0;
      if (!serialMode)
      begin
        rdActive_r <= 1'b0;
        sdoOe <= 1'b0;
      end
      else if (addrDone)
      begin
        rdData_r <= rdValue;
        rdActive_r <= word[7];
      end
      else if (sckFall && rdActive_r && bitCnt_r != `QMC_WORD_BITS)
      begin
        sdoOe <= !rdData_r[7];
        rdData_r <= {rdData_r[6:0], 1'b0};
      end
      else if (sckFall)
        sdoOe <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // Mode decode
  // -------------------------------------------------------------------
  qmc_power_s pwr;
  qmc_output_s outc;
  logic [9:0] baseCurrent;
  logic [1:0] laneNxt;
  logic [4:0] bitsNxt;

  assign pwr = qmc_power_s'(pwrReg_r);
  assign outc = qmc_output_s'(outReg_r);

  // Reserved drive code answers zero current
  always_comb
  begin
    case (outc.driveCurrentSelect)
      3'h0: baseCurrent = `QMC_CUR_3P50;
      3'h1: baseCurrent = `QMC_CUR_4P00;
      3'h2: baseCurrent = `QMC_CUR_4P50;
      3'h4: baseCurrent = `QMC_CUR_3P00;
      3'h5: baseCurrent = `QMC_CUR_2P50;
      3'h6: baseCurrent = `QMC_CUR_2P10;
      3'h7: baseCurrent = `QMC_CUR_1P75;
      default: baseCurrent = `QMC_CUR_NONE;
    endcase
  end

  // Unused serialization codes show as zero lanes
  always_comb
  begin
    case (outc.serializationModeSelect)
      3'h0: {laneNxt, bitsNxt} = {`QMC_LANES_2, `QMC_BITS_16};
      3'h1: {laneNxt, bitsNxt} = {`QMC_LANES_2, `QMC_BITS_14};
      3'h2: {laneNxt, bitsNxt} = {`QMC_LANES_2, `QMC_BITS_12};
      3'h5: {laneNxt, bitsNxt} = {`QMC_LANES_1, `QMC_BITS_14};
      3'h6: {laneNxt, bitsNxt} = {`QMC_LANES_1, `QMC_BITS_12};
      3'h7: {laneNxt, bitsNxt} = {`QMC_LANES_1, `QMC_BITS_16};
      default: {laneNxt, bitsNxt} = 7'h00;
    endcase
  end

  // Registered controls toward the analog side
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      powerCtl <= qmc_power_s'(`QMC_REG_RESET);
      outputCtl <= qmc_output_s'(`QMC_REG_RESET);
      channelEnable <= 4'hf;
      outputsEnable <= 1'b1;
      driveCurrent <= `QMC_CUR_3P50;
      laneCount <= `QMC_LANES_2;
      wordBits <= `QMC_BITS_16;
    end
    else if (ce)
    begin
      powerCtl <= pwr;
      outputCtl <= outc;
      // Sleep overrides every nap bit
      channelEnable <= pwr.sleepMode
        ? 4'h0 : ~pwr.channelNap;
      outputsEnable <= !outc.outputsDisable;
      // Driver current doubles while termination is on
      driveCurrent <= outc.internalTerminationEnable
        ? {baseCurrent[8:0], 1'b0} : baseCurrent;
      laneCount <= laneNxt;
      wordBits <= bitsNxt;
    end
  end

  // -------------------------------------------------------------------
  // Output data formatting
  // -------------------------------------------------------------------
  qmc_sample_t fmt;

  // Format first, then scramble, so decoders undo it in reverse order
  always_comb
  begin
    fmt = sampleIn;
    if (pwr.signedFormatSelect)
      fmt[13] = !sampleIn[13];
    if (pwr.outputScramblerEnable)
      fmt[13:1] = fmt[13:1] ^ {13{fmt[0]}};
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sampleOut <= 14'h0000;
      sampleOutValid <= 1'b0;
    end
    else if (ce)
    begin
      sampleOutValid <= sampleValid && !outc.outputsDisable;
      if (sampleValid)
        sampleOut <= fmt;
    end
  end

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n || !ce);

  sequence readAddrSeen;
    addrDone && word[7];
  endsequence

  sequence readZeroReg;
    addrDone && rdAddr == `QMC_SOFT_RESET_CONTROL;
  endsequence

  reset_reads_zero_a: assert property (
    readZeroReg |=> rdData_r == 8'h00)
    else $error("reset register did not read zero");

  soft_reset_clear_a: assert property (
    softReset |=> pwrReg_r == 8'h00 && outReg_r == 8'h00)
    else $error("soft reset left mode bits set");

  power_write_a: assert property (
    doWrite && !softReset && wrAddr == `QMC_POWER_AND_FORMAT_CONTROL
    |=> ##1 powerCtl == $past(wrData, 2))
    else $error("power register write not visible");

  nap_channels_a: assert property (
    !pwr.sleepMode |=> channelEnable == ~$past(pwr.channelNap))
    else $error("nap bits not mapped to channels");

  sleep_all_off_a: assert property (
    pwr.sleepMode |=> channelEnable == 4'h0)
    else $error("sleep did not disable channels");

  term_double_a: assert property (
    outc.internalTerminationEnable && outc.driveCurrentSelect == 3'h7
    |=> driveCurrent == 10'h15e)
    else $error("termination did not double current");

  scramble_data_a: assert property (
    sampleValid && pwr.outputScramblerEnable && !pwr.signedFormatSelect
    |=> sampleOut[0] == $past(sampleIn[0])
    && sampleOut[13:1] == ($past(sampleIn[13:1]) ^ {13{$past(sampleIn[0])}}))
    else $error("scrambled sample wrong");

  outputs_off_a: assert property (
    outc.outputsDisable |=> !outputsEnable && !sampleOutValid)
    else $error("outputs not disabled");

  ser_mode_a: assert property (
    outc.serializationModeSelect == 3'h5
    |=> laneCount == 2'h1 && wordBits == 5'h0e)
    else $error("serialization decode wrong");

  // A read must arm the shifter with the addressed register's value
  read_load_a: assert property (
    readAddrSeen |=> rdActive_r && rdData_r == $past(rdValue))
    else $error("readback value not loaded");

  read_keeps_regs_a: assert property (
    doCommit && word[`QMC_RW_BIT] |=> $stable(pwrReg_r) && $stable(outReg_r))
    else $error("readback updated a register");

endmodule : qmc_mode_regs

`default_nettype wire

// >>> tb/qmc_host.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------------
// Serial host that programs the configuration port
// ---------------------------------------------------------------------
module qmc_host (
  // Clocking
  input wire logic clock,
  // Serial port
  output qmc_pkg::qmc_pins_s pins,
  input wire logic sdoWire,
  // Readback result
  output logic rdDone,
  output logic [7:0] rdData
);
  import qmc_pkg::*;

  // Idle: deselected and clock low, so no stray edge reaches the device
  initial
  begin
    pins = 4'b1010;
    rdDone = 1'b0;
    rdData = 8'h00;
  end

  // Let n edges pass, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : tick

  // One whole word; each phase is 5 clocks so the synchroniser sees it
  task automatic xfer(input logic rw, input logic [6:0] addr,
                      input logic [7:0] data, input logic par);
    logic [15:0] word;
    logic [7:0] got;
    word = {rw, addr, data};
    got = 8'h00;
    pins.programmingStyleSelect = par;
    pins.csN = 1'b0;
    tick(5);
    for (int i = 0; i < 16; i++)
    begin
      pins.sck = 1'b0;
      pins.sdi = word[15-i];
      tick(5);
      if (i >= 8) got[15-i] = sdoWire;
      pins.sck = 1'b1;
      tick(5);
    end
    pins.sck = 1'b0;
    tick(8);
    pins.csN = 1'b1;
    pins.sdi = ~pins.sdi;
    pins.programmingStyleSelect = 1'b0;
    tick(6);
    if (rw)
    begin
      rdData = got;
      rdDone = 1'b1;
      tick(1);
      rdDone = 1'b0;
    end
  endtask : xfer
endmodule : qmc_host

`default_nettype wire

// >>> tb/qmc_mode_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "qmc_map.svh"

module qmc_mode_regs_tb;
  import qmc_pkg::*;

  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic sampleValid = 1'b0;
  logic snapReq = 1'b0;
  qmc_sample_t sampleIn = '0;
  qmc_pins_s pins;
  logic sdoOut, sdoOe, sdoWire, sampleOutValid, outputsEnable, rdDone;
  qmc_sample_t sampleOut;
  qmc_power_s powerCtl;
  qmc_output_s outputCtl;
  logic [3:0] channelEnable;
  logic [9:0] driveCurrent;
  logic [1:0] laneCount;
  logic [4:0] wordBits;
  logic [7:0] rdData, pw, om;
  logic [37:0] expQ[$];
  logic [31:0] rng = 32'd10;
  logic [31:0] r;
  int miscompares = 0;
  int comparisons = 0;

  // 40 MHz clock
  always #12.5 clock = ~clock;

  // Open drain with pull-up: device only ever pulls low
  assign sdoWire = sdoOe ? sdoOut : 1'b1;

  qmc_mode_regs dut_u (.clock(clock), .rst_n(rst_n), .ce(ce),
    .pins(pins), .sdoOut(sdoOut), .sdoOe(sdoOe), .sampleIn(sampleIn),
    .sampleValid(sampleValid), .sampleOut(sampleOut),
    .sampleOutValid(sampleOutValid), .powerCtl(powerCtl),
    .outputCtl(outputCtl), .channelEnable(channelEnable),
    .outputsEnable(outputsEnable), .driveCurrent(driveCurrent),
    .laneCount(laneCount), .wordBits(wordBits));

  qmc_host host_u (.clock(clock), .pins(pins), .sdoWire(sdoWire),
    .rdDone(rdDone), .rdData(rdData));

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs

  // Expected decode of both mode registers, in snapshot order
  function automatic logic [37:0] snapExp(input logic [7:0] p,
                                          input logic [7:0] o);
    logic [9:0] cur;
    logic [6:0] ser;
    case (o[7:5])
      3'h0: cur = `QMC_CUR_3P50;
      3'h1: cur = `QMC_CUR_4P00;
      3'h2: cur = `QMC_CUR_4P50;
      3'h4: cur = `QMC_CUR_3P00;
      3'h5: cur = `QMC_CUR_2P50;
      3'h6: cur = `QMC_CUR_2P10;
      3'h7: cur = `QMC_CUR_1P75;
      default: cur = `QMC_CUR_NONE;
    endcase
    case (o[2:0])
      3'h0: ser = {`QMC_LANES_2, `QMC_BITS_16};
      3'h1: ser = {`QMC_LANES_2, `QMC_BITS_14};
      3'h2: ser = {`QMC_LANES_2, `QMC_BITS_12};
      3'h5: ser = {`QMC_LANES_1, `QMC_BITS_14};
      3'h6: ser = {`QMC_LANES_1, `QMC_BITS_12};
      3'h7: ser = {`QMC_LANES_1, `QMC_BITS_16};
      default: ser = 7'h00;
    endcase
    if (o[4]) cur = cur << 1;
    return {p, o, ~o[3], p[4] ? 4'h0 : ~p[3:0],
            cur, ser};
  endfunction : snapExp

  task automatic check(input logic [37:0] seen, input logic [37:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : tick

  // Write and keep the register model in step
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_u.xfer(1'b0, a, d, 1'b0);
    if (a == 7'h01) pw = d;
    if (a == 7'h02) om = d;
    if (a == 7'h00 && d[7])
    begin
      pw = 8'h00;
      om = 8'h00;
    end
  endtask : wr

  // Readback; the data field carries noise that must be ignored
  task automatic rd(input logic [6:0] a);
    logic [31:0] noise;
    logic [7:0] e;
    noise = xs();
    e = a == 7'h01 ? pw : a == 7'h02 ? om : 8'h00;
    expQ.push_back({30'h0, e});
    host_u.xfer(1'b1, a, noise[7:0], 1'b0);
  endtask : rd

  task automatic snap();
    expQ.push_back(snapExp(pw, om));
    snapReq = 1'b1;
    tick(1);
    snapReq = 1'b0;
    tick(1);
  endtask : snap

  // Formatted sample: sign flip first, then scramble; none when disabled
  task automatic sendSample(input logic [13:0] v);
    logic [13:0] e;
    e = v;
    e[13] = e[13] ^ pw[5];
    if (pw[6]) e[13:1] = e[13:1] ^ {13{e[0]}};
    if (!om[3]) expQ.push_back({24'h0, e});
    sampleIn = v;
    sampleValid = 1'b1;
    tick(1);
    sampleValid = 1'b0;
    tick(3);
  endtask : sendSample

  task automatic print_verdict();
    $display("counts: %0d comparisons, %0d miscompares", comparisons,
             miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // Watcher: every result that appears takes the oldest note
  always @(posedge clock)
  begin
    if (rdDone === 1'b1 || sampleOutValid === 1'b1 || snapReq)
    begin
      // A result with no note behind it is a mismatch in itself
      if (expQ.size() == 0)
        miscompares++;
      else
        check(rdDone === 1'b1 ? {30'h0, rdData} :
            sampleOutValid === 1'b1 ? {24'h0, sampleOut} :
            {powerCtl, outputCtl, outputsEnable, channelEnable,
             driveCurrent, laneCount, wordBits}, expQ.pop_front());
    end
  end

  // Hang guard
  initial
  begin
    repeat (60000) @(posedge clock);
    miscompares++;
    print_verdict();
  end

  // Main sequence
  initial
  begin
    pw = 8'h00;
    om = 8'h00;
    tick(12);
    rst_n = 1'b1;
    tick(6);
    snap();
    rd(7'h00);
    rd(7'h01);
    rd(7'h02);
    rd(7'h05);
    $display("test defaults done");
    for (int i = 0; i < 8; i++)
    begin
      r = xs();
      wr(7'h01, i == 0 ? r[15:8] & 8'he0 : r[15:8]);
      // Termination only with the three lowest currents
      wr(7'h02, {i[2:0], i == 7 || (i >= 5 && r[4]), r[3], 3'(i * 3)});
      snap();
      rd(7'h01);
      rd(7'h02);
      sendSample(r[29:16]);
    end
    $display("test mode sweep done");
    wr(7'h01, 8'hda);
    wr(7'h02, 8'hb5);
    sendSample(14'h2b5);
    wr(7'h00, 8'h7f);
    wr(7'h05, 8'hff);
    host_u.xfer(1'b0, 7'h01, 8'h00, 1'b1);
    snap();
    rd(7'h01);
    rd(7'h01);
    rd(7'h00);
    $display("test ignored accesses done");
    wr(7'h00, 8'h80);
    snap();
    rd(7'h00);
    rd(7'h01);
    rd(7'h02);
    $display("test soft reset done");
    for (int k = 0; k < 50 && expQ.size() > 0; k++) tick(1);
    if (expQ.size() > 0) miscompares++;
    print_verdict();
  end
endmodule : qmc_mode_regs_tb

`default_nettype wire
